/* design/parallel_port_epp_control.sv */
// parallel port control: host register port, EPP engine and pin drivers
// assumes pins are resolved outside from o/oe pairs; data path is external
module parallel_port_epp_control #(
  parameter int DEPTH = pp_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       io_req,
  input  wire logic       io_we,
  input  wire logic [9:0] io_addr,
  input  wire logic [7:0] io_wdata,
  output logic            io_ack,
  output logic      [7:0] io_rdata,
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_index,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  input  wire logic       video_disable,
  output logic            data_strobe_out_o,
  output logic            data_strobe_out_oe,
  input  wire logic       data_strobe_out_i,
  output logic            auto_linefeed_out_o,
  output logic            auto_linefeed_out_oe,
  input  wire logic       auto_linefeed_out_i,
  output logic            init_line_o,
  output logic            init_line_oe,
  input  wire logic       init_line_i,
  output logic            select_in_line_o,
  output logic            select_in_line_oe,
  input  wire logic       select_in_line_i,
  input  wire logic       ack_in_n,
  input  wire logic       busy_in,
  input  wire logic       paper_end_in,
  input  wire logic       select_in,
  input  wire logic       error_in_n,
  input  wire logic [7:0] port_data_in,
  output logic      [7:0] port_data_out,
  output logic            port_data_latch_write_n,
  output logic            port_latch_output_enable_n,
  output logic            port_buffer_enable_n,
  output logic            irq7_req
);
  typedef enum logic [2:0] {H_IDLE, H_DEC, H_PUSH, H_READ, H_ACK} host_e;
  typedef enum logic [2:0] {E_IDLE, E_STROBE, E_RECOV, E_LATCH, E_SAMPLE} eng_e;

  host_e         h_state_q;
  eng_e          e_state_q;
  logic [16:0]   sync1_q, sync2_q;
  logic [7:0]    map_q, ctrl_q, wdata_q, eng_rdata_q;
  logic [7:0]    stat_s, data_s;
  logic [9:0]    addr_q, fifo_out;
  logic [3:0]    pin_s;
  logic [2:0]    cnt_q;
  logic [1:0]    sel;
  logic          lock_q, we_q, e_read_q, e_addr_q, eng_done_q;
  logic          wait_s, ack_s, epp, card;
  logic          fifo_in_ready, fifo_out_valid, fifo_pop;
  logic          write_act, epp_data_strobe_act, epp_address_strobe_act, rd_start;
  pp_pkg::kind_e push_kind;
  // base address of a selection; zero selection decodes nothing
  function automatic logic [9:0] base_of(input logic [1:0] s);
    unique case (s)
      2'h1:    base_of = pp_pkg::BASE_3B;
      2'h2:    base_of = pp_pkg::BASE_37;
      default: base_of = pp_pkg::BASE_27;
    endcase
  endfunction

  // address hit on one register of the mapped window
  function automatic logic hit(input logic [9:0] a, input logic [1:0] s,
                               input logic [2:0] ofs);
    hit = (s != 2'h0) && (a == 10'(base_of(s) + {7'h00, ofs}));
  endfunction

  assign sel  = map_q[pp_pkg::MAP_SEL_LSB +: 2];
  assign epp  = map_q[pp_pkg::MAP_EPP_BIT];
  assign card = map_q[pp_pkg::MAP_CARD_BIT];

  // two-stage synchroniser for every pin input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= {port_data_in, busy_in, ack_in_n, paper_end_in, select_in,
                  error_in_n, data_strobe_out_i, auto_linefeed_out_i,
                  init_line_i, select_in_line_i};
      sync2_q <= sync1_q;
    end
  end

  // status byte: inverted busy, ack, paper end, select, error
  assign data_s = sync2_q[16:9];
  assign wait_s = sync2_q[8];
  assign ack_s  = sync2_q[7];
  assign stat_s = {!sync2_q[8], sync2_q[7:4], 3'h0};
  assign pin_s  = sync2_q[3:0];

  // mapping lock once the video controller is switched off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 1'b0;
    end else if (ce && video_disable) begin
      lock_q <= 1'b1;
    end
  end

  // mapping register, reachable only while unlocked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      map_q     <= pp_pkg::MAP_RESET;
      cfg_rdata <= 8'h00;
    end else if (ce) begin
      if (cfg_wr && cfg_index == pp_pkg::MAP_INDEX && !lock_q) begin
        map_q <= cfg_wdata;
      end
      if (cfg_rd) begin
        cfg_rdata <= (cfg_index == pp_pkg::MAP_INDEX && !lock_q) ? map_q : 8'h00;
      end
    end
  end

  // port control register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= pp_pkg::CTRL_RESET;
    end else if (ce && h_state_q == H_DEC && we_q &&
                 hit(addr_q, sel, pp_pkg::OFS_CTRL)) begin
      ctrl_q <= wdata_q;
    end
  end

  // kind of a queued data write
  always_comb begin
    push_kind = pp_pkg::K_LATCH;
    if (hit(addr_q, sel, pp_pkg::OFS_EPP_AD)) begin
      push_kind = pp_pkg::K_EPP_ADDR;
    end else if (hit(addr_q, sel, pp_pkg::OFS_EPP_DA)) begin
      push_kind = pp_pkg::K_EPP_DATA;
    end
  end

  // host request sequencer: decode, queue, read wait, answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      h_state_q <= H_IDLE;
      addr_q    <= 10'h000;
      we_q      <= 1'b0;
      wdata_q   <= 8'h00;
      io_ack    <= 1'b0;
      io_rdata  <= 8'h00;
    end else if (ce) begin
      io_ack <= 1'b0;
      unique case (h_state_q)
        H_IDLE: begin
          if (io_req) begin
            addr_q    <= io_addr;
            we_q      <= io_we;
            wdata_q   <= io_wdata;
            h_state_q <= H_DEC;
          end
        end
        H_DEC: begin
          h_state_q <= H_ACK;
          io_rdata  <= pp_pkg::IDLE_BUS;
          if (hit(addr_q, sel, pp_pkg::OFS_DATA) ||
              (epp && (hit(addr_q, sel, pp_pkg::OFS_EPP_AD) ||
                       hit(addr_q, sel, pp_pkg::OFS_EPP_DA)))) begin
            h_state_q <= we_q ? H_PUSH : H_READ;
          end else if (hit(addr_q, sel, pp_pkg::OFS_STAT)) begin
            io_rdata <= we_q ? pp_pkg::IDLE_BUS : stat_s;
          end else if (hit(addr_q, sel, pp_pkg::OFS_CTRL)) begin
            io_rdata <= {2'h0, ctrl_q[5:4], !pin_s[0], pin_s[1], !pin_s[2], !pin_s[3]};
          end
        end
        H_PUSH: begin
          if (fifo_in_ready) begin
            h_state_q <= H_ACK;
          end
        end
        H_READ: begin
          if (eng_done_q) begin
            io_rdata  <= eng_rdata_q;
            h_state_q <= H_ACK;
          end
        end
        H_ACK: begin
          io_ack    <= 1'b1;
          h_state_q <= H_IDLE;
        end
      endcase
    end
  end

  // queue of posted data writes between host and port
  pp_fifo #(
    .WIDTH (pp_pkg::FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .in_valid  (h_state_q == H_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_kind, wdata_q}),
    .out_valid (fifo_out_valid),
    .out_ready (e_state_q == E_IDLE),
    .out_data  (fifo_out)
  );

  assign fifo_pop = fifo_out_valid && e_state_q == E_IDLE;
  assign rd_start = e_state_q == E_IDLE && !fifo_out_valid &&
                    h_state_q == H_READ && !eng_done_q;

  // port engine: latch pulses, buffered reads and EPP handshakes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      e_state_q     <= E_IDLE;
      e_read_q      <= 1'b0;
      e_addr_q      <= 1'b0;
      cnt_q         <= 3'h0;
      eng_done_q    <= 1'b0;
      eng_rdata_q   <= 8'h00;
      port_data_out <= 8'h00;
    end else if (ce) begin
      eng_done_q <= 1'b0;
      unique case (e_state_q)
        E_IDLE: begin
          if (fifo_pop) begin
            port_data_out <= fifo_out[7:0];
            e_read_q      <= 1'b0;
            e_addr_q      <= fifo_out[9:8] == pp_pkg::K_EPP_ADDR;
            e_state_q     <= fifo_out[9:8] == pp_pkg::K_LATCH ? E_LATCH : E_STROBE;
          end else if (rd_start) begin
            e_read_q <= 1'b1;
            e_addr_q <= hit(addr_q, sel, pp_pkg::OFS_EPP_AD);
            cnt_q    <= 3'h0;
            if (hit(addr_q, sel, pp_pkg::OFS_DATA)) begin
              if (ctrl_q[pp_pkg::CTRL_DIR]) begin
                e_state_q <= E_SAMPLE;
              end else begin
                eng_rdata_q <= port_data_out;
                eng_done_q  <= 1'b1;
              end
            end else begin
              e_state_q <= E_STROBE;
            end
          end
        end
        E_STROBE: begin
          if (wait_s) begin
            eng_rdata_q <= data_s;
            e_state_q   <= E_RECOV;
          end
        end
        E_RECOV: begin
          if (!wait_s) begin
            eng_done_q <= e_read_q;
            e_state_q  <= E_IDLE;
          end
        end
        E_LATCH: begin
          e_state_q <= E_IDLE;
        end
        E_SAMPLE: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == pp_pkg::SAMPLE_CYCLES - 3'h1) begin
            eng_rdata_q <= data_s;
            eng_done_q  <= 1'b1;
            e_state_q   <= E_IDLE;
          end
        end
      endcase
    end
  end

  assign write_act = e_state_q == E_STROBE && !e_read_q;
  assign epp_data_strobe_act = e_state_q == E_STROBE && !e_addr_q;
  assign epp_address_strobe_act = e_state_q == E_STROBE && e_addr_q;

  // control pin drivers: open drain in normal mode, push-pull in EPP except the init line and, with card set, select-in
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_strobe_out_o    <= 1'b0;
      data_strobe_out_oe   <= 1'b0;
      auto_linefeed_out_o  <= 1'b0;
      auto_linefeed_out_oe <= 1'b0;
      init_line_o          <= 1'b0;
      init_line_oe         <= 1'b0;
      select_in_line_o     <= 1'b0;
      select_in_line_oe    <= 1'b0;
    end else if (ce) begin
      if (epp) begin
        data_strobe_out_o    <= !write_act;
        data_strobe_out_oe   <= 1'b1;
        auto_linefeed_out_o  <= !epp_data_strobe_act;
        auto_linefeed_out_oe <= 1'b1;
        select_in_line_o     <= !epp_address_strobe_act;
        select_in_line_oe    <= !card;
      end else begin
        data_strobe_out_o    <= 1'b0;
        data_strobe_out_oe   <= ctrl_q[pp_pkg::CTRL_STROBE];
        auto_linefeed_out_o  <= 1'b0;
        auto_linefeed_out_oe <= ctrl_q[pp_pkg::CTRL_AUTOLF];
        select_in_line_o     <= 1'b0;
        select_in_line_oe    <= ctrl_q[pp_pkg::CTRL_SELIN] && !card;
      end
      init_line_o  <= 1'b0;
      init_line_oe <= !ctrl_q[pp_pkg::CTRL_INIT] && !card;
    end
  end

  // latch strobe or data decode, buffer enable, interrupt request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_data_latch_write_n <= 1'b1;
      port_buffer_enable_n    <= 1'b1;
      irq7_req                <= 1'b0;
    end else if (ce) begin
      port_data_latch_write_n <= !(e_state_q == E_LATCH ||
                                   (epp && e_state_q == E_SAMPLE));
      port_buffer_enable_n    <= !(e_state_q == E_SAMPLE ||
                                   (e_state_q == E_STROBE && e_read_q));
      irq7_req <= ctrl_q[pp_pkg::CTRL_IRQEN] && (epp ? ack_s : !ack_s);
    end
  end

  // latch output enable is the control bit itself
  assign port_latch_output_enable_n = ctrl_q[pp_pkg::CTRL_DIR];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n || !ce);

  a_map_frozen_lock: assert property (lock_q |=> $stable(map_q))
    else $error("mapping changed while locked");
  a_cfg_index_only: assert property (cfg_wr && cfg_index != pp_pkg::MAP_INDEX
    |=> $stable(map_q)) else $error("mapping written at wrong index");
  a_oe_follows_bit: assert property (h_state_q == H_DEC && we_q &&
    hit(addr_q, sel, pp_pkg::OFS_CTRL) |=> port_latch_output_enable_n ==
    $past(wdata_q[pp_pkg::CTRL_DIR])) else $error("latch enable not bit 5");
  a_normal_open_drain: assert property (!$past(epp) |-> !data_strobe_out_o &&
    !auto_linefeed_out_o && !select_in_line_o) else $error("drove high");
  a_epp_push_pull: assert property ($past(epp) |-> data_strobe_out_oe &&
    auto_linefeed_out_oe) else $error("EPP pin not driven");
  a_card_pins_off: assert property (card |=> !init_line_oe && !select_in_line_oe)
    else $error("init or select-in driven with card pins");
  a_write_ind: assert property (epp && write_act |=> !data_strobe_out_o)
    else $error("write indication missing");
  a_data_strobe: assert property (epp && epp_data_strobe_act |=> !auto_linefeed_out_o)
    else $error("data strobe missing");
  a_addr_strobe: assert property (epp && epp_address_strobe_act |=> !select_in_line_o)
    else $error("address strobe missing");
  a_wait_holds: assert property (e_state_q == E_STROBE && !wait_s
    |=> e_state_q == E_STROBE) else $error("cycle ended during wait");
  a_unmapped_answer: assert property (h_state_q == H_DEC && sel == 2'h0
    |=> ##1 io_ack && io_rdata == pp_pkg::IDLE_BUS) else $error("disabled decode");
  a_latch_pulse: assert property (e_state_q == E_LATCH |=> !port_data_latch_write_n
    ##1 port_data_latch_write_n) else $error("latch strobe wrong");
  a_buffer_read: assert property (e_state_q == E_SAMPLE |=> !port_buffer_enable_n)
    else $error("buffer not enabled on read");
  a_irq_gated: assert property (irq7_req |-> $past(ctrl_q[pp_pkg::CTRL_IRQEN]))
    else $error("interrupt without enable");

  c_epp_write: cover property (write_act ##[1:50] e_state_q == E_IDLE);
  c_buffer_read: cover property (e_state_q == E_SAMPLE ##[1:8] eng_done_q);
  c_queue_full: cover property (h_state_q == H_PUSH && !fifo_in_ready);
endmodule

/* design/pp_pkg.sv */
// constants, encodings and field positions of the parallel port block
// assumes a single system clock domain and an active-low asynchronous reset
package pp_pkg;
  // mapping register in the video controller index space
  localparam logic [7:0] MAP_INDEX    = 8'h20;
  localparam logic [7:0] MAP_RESET    = 8'h00;
  localparam int         MAP_SEL_LSB  = 0;
  localparam int         MAP_EPP_BIT  = 2;
  localparam int         MAP_CARD_BIT = 3;
  // base selections: 0 disabled, 1..3 the three windows
  localparam logic [9:0] BASE_3B = 10'h03bc;
  localparam logic [9:0] BASE_37 = 10'h0378;
  localparam logic [9:0] BASE_27 = 10'h0278;
  // register offsets from the base
  localparam logic [2:0] OFS_DATA   = 3'h0;
  localparam logic [2:0] OFS_STAT   = 3'h1;
  localparam logic [2:0] OFS_CTRL   = 3'h2;
  localparam logic [2:0] OFS_EPP_AD = 3'h3;
  localparam logic [2:0] OFS_EPP_DA = 3'h4;
  // control register fields
  localparam int         CTRL_STROBE = 0;
  localparam int         CTRL_AUTOLF = 1;
  localparam int         CTRL_INIT   = 2;
  localparam int         CTRL_SELIN  = 3;
  localparam int         CTRL_IRQEN  = 4;
  localparam int         CTRL_DIR    = 5;
  localparam logic [7:0] CTRL_RESET  = 8'h04;
  // answer for an address the port does not decode
  localparam logic [7:0] IDLE_BUS    = 8'hff;
  // write queue and read sampling
  localparam int         FIFO_DEPTH    = 8;
  localparam int         FIFO_WIDTH    = 10;
  localparam logic [2:0] SAMPLE_CYCLES = 3'h4;
  // kind of a queued transfer
  typedef enum logic [1:0] {K_LATCH, K_EPP_DATA, K_EPP_ADDR} kind_e;
endpackage

/* design/pp_fifo.sv */
// synchronous write queue with valid/ready on both sides
// assumes DEPTH is a power of two; one clock, clock enable freezes it
module pp_fifo #(
  parameter int WIDTH = pp_pkg::FIFO_WIDTH,
  parameter int DEPTH = pp_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                       (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign out_data  = mem[rd_ptr_q[AW-1:0]];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule

/* sim/pp_periph.sv */
// behavioural far side: output latch, input buffer and EPP peripheral
// assumes control pin levels are already resolved with pull-ups
module pp_periph (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] wait_cycles,
  input  wire logic       svc_req,
  input  wire logic [7:0] rd_byte,
  input  wire logic       write_lvl,
  input  wire logic       epp_data_strobe_lvl,
  input  wire logic       epp_address_strobe_lvl,
  input  wire logic [7:0] port_data_out,
  input  wire logic       port_data_latch_write_n,
  input  wire logic       port_buffer_enable_n,
  output logic            busy_in,
  output logic            ack_in_n,
  output logic      [7:0] port_data_in,
  output logic      [7:0] latch_q,
  output logic      [7:0] epp_data_q,
  output logic      [7:0] epp_addr_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // buffer off: bus shows the inverse, never a stale value
  assign port_data_in = port_buffer_enable_n ? ~rd_byte : rd_byte;
  // service request, high active in EPP
  assign ack_in_n = svc_req;
  // external latch grabs the byte on the write strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_q <= 8'h00;
    end else if (!port_data_latch_write_n) begin
      latch_q <= port_data_out;
    end
  end
  // wait line: done after wait_cycles, back low once strobes released
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
      busy_in <= 1'b0;
      epp_data_q <= 8'h00;
      epp_addr_q <= 8'h00;
    end else if (epp_data_strobe_lvl && epp_address_strobe_lvl) begin
      cnt_q <= 4'h0;
      busy_in <= 1'b0;
    end else if (cnt_q < wait_cycles) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (!busy_in) begin
      busy_in <= 1'b1;
      if (!write_lvl && !epp_data_strobe_lvl) epp_data_q <= port_data_out;
      if (!write_lvl && !epp_address_strobe_lvl) epp_addr_q <= port_data_out;
    end
  end
endmodule

/* sim/parallel_port_epp_control_tb_top.sv */
// testbench: host and config bus tasks, peripheral model, verdict
// assumes 20 MHz clock and inputs driven on the falling edge
module parallel_port_epp_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, arst_n = 1'b0, ce = 1'b1, io_req = 1'b0, io_we = 1'b0;
  logic       cfg_wr = 1'b0, cfg_rd = 1'b0, video_disable = 1'b0, svc_req = 1'b0;
  logic [9:0] io_addr = 10'h000;
  logic [7:0] io_wdata = 8'h00, cfg_index = 8'h00, cfg_wdata = 8'h00, rd_byte = 8'h00;
  logic [3:0] wait_cycles = 4'h0;
  logic       io_ack, data_strobe_out_o, data_strobe_out_oe, auto_linefeed_out_o;
  logic       auto_linefeed_out_oe, init_line_o, init_line_oe, select_in_line_o;
  logic       select_in_line_oe, ack_in_n, busy_in, port_data_latch_write_n;
  logic       port_latch_output_enable_n, port_buffer_enable_n, irq7_req;
  logic [7:0] io_rdata, cfg_rdata, port_data_in, port_data_out, latch_q, epp_data_q;
  logic [7:0] epp_addr_q, q;
  wire        stb_lvl = data_strobe_out_oe ? data_strobe_out_o : 1'b1;
  wire        alf_lvl = auto_linefeed_out_oe ? auto_linefeed_out_o : 1'b1;
  wire        ini_lvl = init_line_oe ? init_line_o : 1'b1;
  wire        sel_lvl = select_in_line_oe ? select_in_line_o : 1'b1;
  int         fails = 0, total_checks = 0;
  // clock
  always #25 clk = ~clk;
  parallel_port_epp_control parallel_port_epp_control_i (.clk, .arst_n, .ce, .io_req, .io_we,
    .io_addr, .io_wdata, .io_ack, .io_rdata, .cfg_wr, .cfg_rd, .cfg_index, .cfg_wdata,
    .cfg_rdata, .video_disable, .data_strobe_out_o, .data_strobe_out_oe,
    .data_strobe_out_i(stb_lvl), .auto_linefeed_out_o, .auto_linefeed_out_oe,
    .auto_linefeed_out_i(alf_lvl), .init_line_o, .init_line_oe, .init_line_i(ini_lvl),
    .select_in_line_o, .select_in_line_oe, .select_in_line_i(sel_lvl), .ack_in_n, .busy_in,
    .paper_end_in(1'b0), .select_in(1'b1), .error_in_n(1'b1), .port_data_in, .port_data_out,
    .port_data_latch_write_n, .port_latch_output_enable_n, .port_buffer_enable_n, .irq7_req);
  pp_periph pp_periph_i (.clk, .arst_n, .wait_cycles, .svc_req, .rd_byte, .write_lvl(stb_lvl),
    .epp_data_strobe_lvl(alf_lvl), .epp_address_strobe_lvl(sel_lvl), .port_data_out, .port_data_latch_write_n,
    .port_buffer_enable_n, .busy_in, .ack_in_n, .port_data_in, .latch_q, .epp_data_q,
    .epp_addr_q);
  // verdict and end of run
  task automatic stop_test;
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one host access, request for one cycle, then wait up to 300 cycles for the answer pulse
  task automatic io(input logic we, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    io_req = 1'b1;
    io_we = we;
    io_addr = a;
    io_wdata = d;
    @(negedge clk);
    io_req = 1'b0;
    n = 0;
    while (io_ack !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) fails++;
    q = io_rdata;
  endtask
  // one config access in the video index space
  task automatic cfg(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = wr;
    cfg_rd = !wr;
    cfg_index = idx;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    q = cfg_rdata;
  endtask
  function automatic logic [9:0] adr(input logic [1:0] s, input logic [2:0] o);
    logic [9:0] b;
    b = (s == 2'h1) ? pp_pkg::BASE_3B : (s == 2'h2) ? pp_pkg::BASE_37 : pp_pkg::BASE_27;
    return b + {7'h00, o};
  endfunction
  // reset state and the three windows
  task automatic t_map;
    cfg(1'b0, 8'h20, 8'h00);
    chk(8'h00, q);
    chk(8'h00, {7'h00, port_latch_output_enable_n});
    io(1'b0, adr(2'h2, pp_pkg::OFS_CTRL), 8'h00);
    chk(8'hff, q);
    for (int s = 1; s <= 3; s++) begin
      cfg(1'b1, 8'h20, 8'(s));
      cfg(1'b1, 8'h21, 8'h00);
      cfg(1'b0, 8'h20, 8'h00);
      chk(8'(s), q);
      io(1'b1, adr(2'(s), pp_pkg::OFS_CTRL), 8'h24);
      io(1'b0, adr(2'(s), pp_pkg::OFS_CTRL), 8'h00);
      chk(8'h24, q);
      io(1'b0, adr(2'(s % 3 + 1), pp_pkg::OFS_CTRL), 8'h00);
      chk(8'hff, q);
      chk(8'h01, {7'h00, port_latch_output_enable_n});
    end
  endtask
  // normal mode: latch write, open-drain pins, buffered read
  task automatic t_normal;
    cfg(1'b1, 8'h20, 8'h01);
    io(1'b1, adr(2'h1, pp_pkg::OFS_CTRL), 8'h05);
    io(1'b1, adr(2'h1, pp_pkg::OFS_DATA), 8'h5a);
    io(1'b0, adr(2'h1, pp_pkg::OFS_STAT), 8'h00);
    chk(8'h98, q);
    chk(8'h5a, latch_q);
    chk(8'h02, {6'h00, data_strobe_out_oe, data_strobe_out_o});
    io(1'b0, adr(2'h1, pp_pkg::OFS_DATA), 8'h00);
    chk(8'h5a, q);
    io(1'b1, adr(2'h1, pp_pkg::OFS_CTRL), 8'h24);
    idle(2);
    chk(8'h00, {7'h00, data_strobe_out_oe});
    rd_byte = 8'hc3;
    io(1'b0, adr(2'h1, pp_pkg::OFS_DATA), 8'h00);
    chk(8'hc3, q);
  endtask
  // EPP mode: strobes, slow wait, service request, card pins, lock
  task automatic t_epp;
    cfg(1'b1, 8'h20, 8'h05);
    io(1'b1, adr(2'h1, pp_pkg::OFS_CTRL), 8'h14);
    idle(2);
    chk(8'h03, {6'h00, data_strobe_out_oe, auto_linefeed_out_o});
    wait_cycles = 4'h5;
    rd_byte = 8'h96;
    io(1'b1, adr(2'h1, pp_pkg::OFS_EPP_DA), 8'ha5);
    io(1'b1, adr(2'h1, pp_pkg::OFS_EPP_AD), 8'h3c);
    io(1'b0, adr(2'h1, pp_pkg::OFS_EPP_DA), 8'h00);
    chk(8'h96, q);
    chk(8'ha5, epp_data_q);
    chk(8'h3c, epp_addr_q);
    svc_req = 1'b1;
    idle(5);
    chk(8'h01, {7'h00, irq7_req});
    svc_req = 1'b0;
    idle(5);
    chk(8'h00, {7'h00, irq7_req});
    cfg(1'b1, 8'h20, 8'h0d);
    idle(2);
    chk(8'h00, {7'h00, select_in_line_oe});
    video_disable = 1'b1;
    idle(1);
    video_disable = 1'b0;
    cfg(1'b1, 8'h20, 8'h02);
    cfg(1'b0, 8'h20, 8'h00);
    chk(8'h00, q);
    io(1'b0, adr(2'h1, pp_pkg::OFS_CTRL), 8'h00);
    chk(8'h14, q);
  endtask
  // watchdog
  initial begin
    #(50 * 5000);
    fails++;
    stop_test;
  end
  // main sequence
  initial begin
    idle(5);
    arst_n = 1'b1;
    t_map;
    t_normal;
    t_epp;
    stop_test;
  end
endmodule
